/* exec_pkg.sv */
// Shared constants and types of the special instruction executor.
// Assumes one 100 MHz clock and a synchronous active low reset.
package exec_pkg;
	localparam int WORD_W = 24;
	localparam int ADDR_W = 12;
	localparam int IDX_W = 3;
	localparam logic [11:0] RESET_PC = 12'h000;
	localparam logic [11:0] DIAG_FP_ADDR = 12'h010;
	localparam logic [11:0] DIAG_IO_ADDR = 12'h020;
	localparam logic [11:0] ADDR_ZERO = 12'h000;
	localparam logic [11:0] ADDR_ONE = 12'h001;
	localparam logic [11:0] ADDR_TWO = 12'h002;
	localparam logic [23:0] WORD_ZERO = 24'h000000;
	localparam logic [2:0] NO_INDEX = 3'h0;

	typedef logic [23:0] word_t;
	typedef logic [11:0] addr_t;

	// Operation codes of the executor
	typedef enum logic [4:0] {
		op_nop = 5'b00000,
		op_add = 5'b00001,
		op_clear_add = 5'b00010,
		op_divide = 5'b00011,
		op_multiply_accumulate = 5'b00100,
		op_or_merge_store = 5'b00101,
		op_xor_add_store = 5'b00110,
		op_select_smaller_word = 5'b00111,
		op_select_larger_word = 5'b01000,
		op_load_accumulator_from_memory = 5'b01001,
		op_load_operand = 5'b01010,
		op_load_multiplier = 5'b01011,
		op_jump = 5'b01100,
		op_issue_io_command = 5'b01101,
		op_skip_on_count_check = 5'b01110,
		op_skip_on_fault = 5'b01111,
		op_repeat_next = 5'b10000,
		op_load_index = 5'b10001
	} op_t;

	// Decoded instruction as presented to the executor
	typedef struct packed {
		op_t op;
		logic fp;
		logic from_q;
		logic absval;
		logic store;
		logic right_half;
		logic [2:0] idx_sel;
		logic idx_sub;
		addr_t addr;
	} instr_t;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_read = 2'b01,
		st_exec = 2'b10,
		st_io = 2'b11
	} state_t;
endpackage

/* ea_if.sv */
// Address formation signals between the executor and its index unit.
// Assumes the executor drives the request side combinationally.
`timescale 1ns/1ps
`default_nettype none
interface ea_if;
	logic [2:0] idx_sel;
	logic idx_sub;
	exec_pkg::addr_t addr;
	exec_pkg::addr_t ea;
	logic ld;
	exec_pkg::addr_t ld_val;
	modport ctrl (output idx_sel, output idx_sub, output addr, output ld, output ld_val, input ea);
	modport unit (input idx_sel, input idx_sub, input addr, input ld, input ld_val, output ea);
endinterface
`default_nettype wire

/* ea_unit.sv */
// Index registers and effective address adder.
// Assumes ld is a one-cycle request from the executor.
`timescale 1ns/1ps
`default_nettype none
module ea_unit (
	input wire logic ref_clk,
	input wire logic rst_n,
	ea_if.unit eu
);
	typedef struct packed {
		exec_pkg::addr_t [7:0] x;
	} ea_st_t;

	ea_st_t st_q;
	ea_st_t st_d;
	exec_pkg::addr_t xv;

	// Load an index register; index 0 is never written
	always_comb
	begin
		st_d = st_q;
		if (eu.ld && eu.idx_sel != exec_pkg::NO_INDEX)
		begin
			st_d.x[eu.idx_sel] = eu.ld_val;
		end
	end

	// Index 0 means plain address; others add or subtract
	always_comb
	begin
		xv = (eu.idx_sel == exec_pkg::NO_INDEX) ? exec_pkg::ADDR_ZERO : st_q.x[eu.idx_sel];
		eu.ea = eu.idx_sub ? eu.addr - xv : eu.addr + xv;
	end

	// State register
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end
endmodule // ea_unit
`default_nettype wire

/* word_alu.sv */
// Combinational arithmetic for the executor: sums, products, quotients.
// Assumes 24-bit fractions; float words hold an 8-bit exponent and 16-bit mantissa.
`timescale 1ns/1ps
`default_nettype none
module word_alu (
	input wire logic fp,
	input wire exec_pkg::word_t base,
	input wire exec_pkg::word_t opnd,
	input wire exec_pkg::word_t acc,
	input wire exec_pkg::word_t mq,
	input wire exec_pkg::word_t mem,
	output logic [23:0] sum,
	output logic sum_ovf,
	output logic exp_ovf,
	output logic [23:0] mac,
	output logic div_ovf,
	output logic [23:0] quot,
	output logic [23:0] rem
);
	logic signed [24:0] fsum;
	logic [7:0] ea;
	logic [7:0] eb;
	logic [7:0] eh;
	logic signed [15:0] ma;
	logic signed [15:0] mb;
	logic signed [16:0] ms;
	logic signed [47:0] prod;
	logic signed [47:0] num;
	logic signed [47:0] den;
	logic signed [47:0] qt;
	logic signed [47:0] rm;
	logic [23:0] mag_a;
	logic [23:0] mag_m;

	// Sum in fixed or floating form
	always_comb
	begin
		fsum = {base[23], base} + {opnd[23], opnd};
		ea = base[23:16];
		eb = opnd[23:16];
		ma = base[15:0];
		mb = opnd[15:0];
		if (ea >= eb)
		begin
			eh = ea;
			mb = mb >>> (ea - eb);
		end
		else
		begin
			eh = eb;
			ma = ma >>> (eb - ea);
		end
		ms = {ma[15], ma} + {mb[15], mb};
		exp_ovf = 1'b0;
		sum_ovf = 1'b0;
		if (fp)
		begin
			sum = {eh, ms[15:0]};
			if (ms[16] != ms[15])
			begin
				sum = {eh + 8'h01, ms[16:1]};
				exp_ovf = (eh == 8'hff);
			end
		end
		else
		begin
			sum = fsum[23:0];
			sum_ovf = fsum[24] != fsum[23];
		end
	end

	// Rounded product added to the accumulator
	always_comb
	begin
		prod = $signed(mem) * $signed(mq) + 48'sh000000400000;
		mac = acc + prod[46:23];
	end

	// Division with the overflow caught beforehand
	always_comb
	begin
		mag_a = acc[23] ? -acc : acc;
		mag_m = mem[23] ? -mem : mem;
		div_ovf = mag_m <= mag_a;
		num = {acc[23], acc, 23'h000000};
		den = div_ovf ? 48'sh1 : {{24{mem[23]}}, mem};
		qt = num / den;
		rm = num % den;
		quot = qt[23:0];
		rem = rm[46:23];
	end
endmodule // word_alu
`default_nettype wire

/* special_instruction_execute.sv */
// Executor for the special, merge, repeat and input-output instructions.
// Assumes memory answers a read one cycle after mem_rd and that the
// controllers present the selected counter and fault status as levels.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - A count-check skip passes over the next instruction when the address field is at least the selected counter.
// - The OR merge stores operand buffer OR memory word into the operand buffer and memory.
// - The carry-less add stores memory XOR accumulator into the operand buffer and memory.
// - Issuing an io command hands the operand buffer word to the controller, which accepts or refuses it.
// - The io issue ends as soon as the command is taken and execution then goes on.
// - A division that would overflow is caught first and the dividend is shifted one place.
// - A floating exponent overflow forces a jump to the diagnostic routine.
// - Every jump taken records the next sequential address in the return link register.
// - An io command that cannot be accepted is bypassed by a jump to the diagnostic routine.
// - The repeat instruction executes the next instruction or pair up to 4095 times in all.
// - Multiply-accumulate adds the product of memory word and multiplier to the accumulator.
// - Smaller and larger word selection keeps that word in the accumulator and its address in the link.
// - A floating prefix runs add and clear add in floating mode.
// - Add and clear add take memory or multiplier, optionally absolute, and optionally store.
// - The address field may name an index register added to or subtracted from the address.
// - The fault skip passes over the next instruction when no io fault exists.
module special_instruction_execute (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic instr_valid,
	input wire exec_pkg::instr_t instr,
	output logic instr_ready,
	output logic [11:0] pc,
	output logic mem_rd,
	output logic mem_we,
	output logic [11:0] mem_addr,
	output logic [23:0] mem_wdata,
	input wire logic [23:0] mem_rdata,
	output logic io_req,
	output logic [23:0] io_cmd,
	input wire logic io_accept,
	input wire logic io_refuse,
	input wire logic io_fault,
	input wire logic [11:0] io_count,
	output logic [23:0] acc,
	output logic [23:0] operand_buf,
	output logic [23:0] multiplier,
	output logic [11:0] return_link_register,
	output logic overflow,
	output logic diag_jump
);
	typedef struct packed {
		exec_pkg::state_t state;
		exec_pkg::instr_t cur;
		exec_pkg::addr_t pc;
		exec_pkg::word_t acc;
		exec_pkg::word_t d;
		exec_pkg::word_t q;
		exec_pkg::addr_t link;
		logic ovf;
		exec_pkg::addr_t rpt_cnt;
		logic rpt_pair;
		logic rpt_phase;
		logic ready;
		logic mem_rd;
		logic mem_we;
		exec_pkg::addr_t mem_addr;
		exec_pkg::word_t mem_wdata;
		logic io_req;
		exec_pkg::word_t io_cmd;
		logic diag;
	} st_t;

	st_t st_q;
	st_t st_d;
	logic fin;
	logic taken;
	logic skip;
	logic is_rpt;
	exec_pkg::addr_t target;
	exec_pkg::word_t w;
	exec_pkg::word_t base;
	exec_pkg::word_t src;
	exec_pkg::word_t opnd;
	logic [23:0] sum;
	logic sum_ovf;
	logic exp_ovf;
	logic [23:0] mac;
	logic div_ovf;
	logic [23:0] quot;
	logic [23:0] rem;

	ea_if eu ();

	ea_unit u_ea (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.eu(eu)
	);

	// Address request from the instruction being accepted
	assign eu.idx_sel = instr.idx_sel;
	assign eu.idx_sub = instr.idx_sub;
	assign eu.addr = instr.addr;
	assign eu.ld = st_q.ready && instr_valid && instr.op == exec_pkg::op_load_index;
	assign eu.ld_val = st_q.d[11:0];

	// Operand selection for add and clear add
	assign base = (st_q.cur.op == exec_pkg::op_clear_add) ? exec_pkg::WORD_ZERO : st_q.acc;
	assign src = st_q.cur.from_q ? st_q.q : mem_rdata;
	assign opnd = (st_q.cur.absval && src[23]) ? -src : src;

	word_alu u_alu (
		.fp(st_q.cur.fp),
		.base(base),
		.opnd(opnd),
		.acc(st_q.acc),
		.mq(st_q.q),
		.mem(mem_rdata),
		.sum(sum),
		.sum_ovf(sum_ovf),
		.exp_ovf(exp_ovf),
		.mac(mac),
		.div_ovf(div_ovf),
		.quot(quot),
		.rem(rem)
	);

	// Sequencer: accept, read operand, execute, then pick the next address
	always_comb
	begin
		st_d = st_q;
		st_d.mem_we = 1'b0;
		st_d.diag = 1'b0;
		fin = 1'b0;
		taken = 1'b0;
		skip = 1'b0;
		target = st_q.mem_addr;
		w = st_q.d;
		is_rpt = st_q.cur.op == exec_pkg::op_repeat_next;
		case (st_q.state)
			exec_pkg::st_idle:
			begin
				if (instr_valid)
				begin
					st_d.cur = instr;
					st_d.ready = 1'b0;
					st_d.mem_addr = eu.ea;
					st_d.mem_rd = 1'b1;
					st_d.state = exec_pkg::st_read;
				end
			end
			exec_pkg::st_read:
			begin
				st_d.mem_rd = 1'b0;
				st_d.state = exec_pkg::st_exec;
			end
			exec_pkg::st_exec:
			begin
				fin = 1'b1;
				case (st_q.cur.op)
					exec_pkg::op_add, exec_pkg::op_clear_add:
					begin
						if (exp_ovf)
						begin
							taken = 1'b1;
							target = exec_pkg::DIAG_FP_ADDR;
							st_d.diag = 1'b1;
						end
						else
						begin
							st_d.acc = sum;
							st_d.ovf = st_q.ovf | sum_ovf;
							if (st_q.cur.store)
							begin
								st_d.mem_we = 1'b1;
								st_d.mem_wdata = sum;
								st_d.d = sum;
							end
						end
					end
					exec_pkg::op_multiply_accumulate:
						st_d.acc = mac;
					exec_pkg::op_divide:
					begin
						if (div_ovf)
						begin
							st_d.acc = {st_q.acc[23], st_q.acc[23:1]};
							st_d.ovf = 1'b1;
						end
						else
						begin
							st_d.q = quot;
							st_d.acc = rem;
							if (st_q.cur.store)
							begin
								st_d.mem_we = 1'b1;
								st_d.mem_wdata = quot;
								st_d.d = quot;
							end
						end
					end
					exec_pkg::op_or_merge_store, exec_pkg::op_xor_add_store:
					begin
						if (st_q.cur.op == exec_pkg::op_or_merge_store)
							w = st_q.d | mem_rdata;
						else
							w = mem_rdata ^ st_q.acc;
						st_d.d = w;
						st_d.mem_we = 1'b1;
						st_d.mem_wdata = w;
					end
					exec_pkg::op_select_smaller_word:
					begin
						if ($signed(mem_rdata) < $signed(st_q.acc))
						begin
							st_d.acc = mem_rdata;
							st_d.link = st_q.mem_addr;
						end
					end
					exec_pkg::op_select_larger_word:
					begin
						if ($signed(mem_rdata) > $signed(st_q.acc))
						begin
							st_d.acc = mem_rdata;
							st_d.link = st_q.mem_addr;
						end
					end
					exec_pkg::op_load_accumulator_from_memory:
						st_d.acc = mem_rdata;
					exec_pkg::op_load_operand:
						st_d.d = mem_rdata;
					exec_pkg::op_load_multiplier:
						st_d.q = mem_rdata;
					exec_pkg::op_jump:
						taken = 1'b1;
					exec_pkg::op_issue_io_command:
					begin
						if (io_fault)
						begin
							taken = 1'b1;
							target = exec_pkg::DIAG_IO_ADDR;
							st_d.diag = 1'b1;
						end
						else
						begin
							fin = 1'b0;
							st_d.io_req = 1'b1;
							st_d.io_cmd = st_q.d;
							st_d.state = exec_pkg::st_io;
						end
					end
					exec_pkg::op_skip_on_count_check:
						skip = st_q.cur.addr >= io_count;
					exec_pkg::op_skip_on_fault:
						skip = !io_fault;
					exec_pkg::op_repeat_next:
					begin
						st_d.rpt_cnt = st_q.cur.addr;
						st_d.rpt_pair = st_q.cur.right_half;
						st_d.rpt_phase = 1'b0;
					end
					default:
						w = st_q.d;
				endcase
			end
			exec_pkg::st_io:
			begin
				if (io_accept)
				begin
					fin = 1'b1;
					st_d.io_req = 1'b0;
				end
				else if (io_refuse)
				begin
					fin = 1'b1;
					taken = 1'b1;
					target = exec_pkg::DIAG_IO_ADDR;
					st_d.diag = 1'b1;
					st_d.io_req = 1'b0;
				end
			end
			default:
				st_d.state = exec_pkg::st_idle;
		endcase

		// Next address: jump, skip, repeat or plain sequence
		if (fin)
		begin
			st_d.state = exec_pkg::st_idle;
			st_d.ready = 1'b1;
			st_d.pc = st_q.pc + exec_pkg::ADDR_ONE;
			if (taken)
			begin
				st_d.pc = target;
				st_d.link = st_q.pc + exec_pkg::ADDR_ONE;
				st_d.rpt_cnt = exec_pkg::ADDR_ZERO;
			end
			else if (skip)
			begin
				st_d.pc = st_q.pc + exec_pkg::ADDR_TWO;
				st_d.rpt_cnt = exec_pkg::ADDR_ZERO;
			end
			else if (st_q.rpt_cnt != exec_pkg::ADDR_ZERO && !is_rpt)
			begin
				if (st_q.rpt_pair && !st_q.rpt_phase)
					st_d.rpt_phase = 1'b1;
				else
				begin
					st_d.rpt_phase = 1'b0;
					st_d.rpt_cnt = st_q.rpt_cnt - exec_pkg::ADDR_ONE;
					if (st_q.rpt_cnt != exec_pkg::ADDR_ONE)
						st_d.pc = st_q.rpt_pair ? st_q.pc - exec_pkg::ADDR_ONE : st_q.pc;
				end
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			st_q <= '0;
			st_q.pc <= exec_pkg::RESET_PC;
			st_q.ready <= 1'b1;
		end
		else
			st_q <= st_d;
	end

	// Outputs straight from the state register
	assign instr_ready = st_q.ready;
	assign pc = st_q.pc;
	assign mem_rd = st_q.mem_rd;
	assign mem_we = st_q.mem_we;
	assign mem_addr = st_q.mem_addr;
	assign mem_wdata = st_q.mem_wdata;
	assign io_req = st_q.io_req;
	assign io_cmd = st_q.io_cmd;
	assign acc = st_q.acc;
	assign operand_buf = st_q.d;
	assign multiplier = st_q.q;
	assign return_link_register = st_q.link;
	assign overflow = st_q.ovf;
	assign diag_jump = st_q.diag;
endmodule // special_instruction_execute
`default_nettype wire

/* exec_chk.sv */
// Port timing checker of the special instruction executor.
// Assumes one clock domain and a synchronous active low reset.
`timescale 1ns/1ps
`default_nettype none
module exec_chk (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire logic [11:0] pc,
	input wire logic mem_rd,
	input wire logic mem_we,
	input wire logic io_req,
	input wire logic [23:0] io_cmd,
	input wire logic io_accept,
	input wire logic io_refuse,
	input wire logic overflow,
	input wire logic diag_jump
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	// Accepted instruction reads memory next cycle
	a_take_then_read: assert property (instr_valid && instr_ready |=> mem_rd && !instr_ready)
		else $error("no read after instruction taken");
	// Command stands until the controller answers
	a_io_cmd_hold: assert property (io_req && !io_accept && !io_refuse |=> io_req && $stable(io_cmd))
		else $error("io command dropped early");
	// Issue ends right after acceptance
	a_io_accept_done: assert property (io_req && io_accept |=> !io_req && instr_ready)
		else $error("io issue not finished after accept");
	// Refused command diverts to the diagnostic routine
	a_io_refuse_diag: assert property (io_req && !io_accept && io_refuse |=> diag_jump && pc == exec_pkg::DIAG_IO_ADDR)
		else $error("refused command not diverted");
	// Executor stays busy while a command is offered
	a_io_busy: assert property (io_req |-> !instr_ready)
		else $error("ready during io command");
	// Read is a single pulse with no write behind it
	a_read_pulse: assert property (mem_rd |=> !mem_rd && !mem_we)
		else $error("read pulse malformed");
	// A store always follows the operand read
	a_store_after_read: assert property ($rose(mem_we) |-> $past(mem_rd, 2))
		else $error("store without operand read");
	// Diagnostic jump is a one-cycle pulse
	a_diag_pulse: assert property (diag_jump |=> !diag_jump)
		else $error("diagnostic pulse too long");
	// Overflow indicator holds once set
	a_ovf_sticky: assert property (overflow |=> overflow)
		else $error("overflow indicator lost");
endmodule // exec_chk

bind special_instruction_execute exec_chk i_exec_chk (.ref_clk, .rst_n, .instr_valid, .instr_ready,
	.pc, .mem_rd, .mem_we, .io_req, .io_cmd, .io_accept, .io_refuse, .overflow, .diag_jump);
`default_nettype wire

/* io_ctrl_model.sv */
// Behavioural model of the input-output controllers.
// Assumes the bench sets answer latency and refusal mode.
`timescale 1ns/1ps
`default_nettype none
module io_ctrl_model (
	input wire logic ref_clk,
	input wire logic io_req,
	input wire logic [23:0] io_cmd,
	input wire logic [3:0] lat,
	input wire logic refuse_mode,
	output logic io_accept,
	output logic io_refuse,
	output logic [23:0] last_cmd,
	output logic [7:0] n_cmd
);
	logic [3:0] cnt_q;
	// Idle controller at time zero
	initial
	begin
		io_accept = 1'b0;
		io_refuse = 1'b0;
		cnt_q = 4'h0;
		n_cmd = 8'h00;
		last_cmd = 24'h000000;
	end
	// Answer after lat cycles, take the command when accepting
	always @(posedge ref_clk)
	begin
		if (io_req && !io_accept && !io_refuse && cnt_q == lat)
		begin
			io_accept <= !refuse_mode;
			io_refuse <= refuse_mode;
			last_cmd <= refuse_mode ? last_cmd : io_cmd;
			n_cmd <= n_cmd + {7'h00, !refuse_mode};
		end
		else
		begin
			io_accept <= 1'b0;
			io_refuse <= 1'b0;
			cnt_q <= (io_req && !io_accept && !io_refuse) ? cnt_q + 4'h1 : 4'h0;
		end
	end
endmodule // io_ctrl_model
`default_nettype wire

/* tb_top.sv */
// Self-checking bench of the special instruction executor.
// Assumes the io controller model and a one-cycle memory in the bench.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic ref_clk, rst_n, instr_valid, instr_ready, mem_rd, mem_we, io_req, io_accept, io_refuse;
	logic io_fault, overflow, diag_jump, refuse_mode;
	logic [11:0] pc, mem_addr, io_count, return_link_register;
	logic [23:0] mem_wdata, mem_rdata, io_cmd, acc, operand_buf, multiplier, last_cmd;
	logic [3:0] lat;
	logic [7:0] n_cmd;
	exec_pkg::instr_t instr;
	exec_pkg::word_t mem [0:4095];
	int error_cnt, cmp_count;

	special_instruction_execute i_special_instruction_execute (.ref_clk, .rst_n, .instr_valid,
		.instr, .instr_ready, .pc, .mem_rd, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .io_req,
		.io_cmd, .io_accept, .io_refuse, .io_fault, .io_count, .acc, .operand_buf, .multiplier,
		.return_link_register, .overflow, .diag_jump);
	io_ctrl_model i_io_ctrl_model (.ref_clk, .io_req, .io_cmd, .lat, .refuse_mode, .io_accept,
		.io_refuse, .last_cmd, .n_cmd);

	// Clock
	always #5 ref_clk = ~ref_clk;
	// Memory answers one cycle after the read, stale data inverted
	always @(posedge ref_clk)
	begin
		if (mem_we) mem[mem_addr] <= mem_wdata;
		mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
	end

	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic exec_pkg::instr_t mk(input exec_pkg::op_t op, input logic [11:0] a);
		mk = '0;
		mk.op = op;
		mk.addr = a;
	endfunction

	// Offer one instruction, wait for completion and the store edge
	task automatic run(input exec_pkg::instr_t i);
		int n;
		@(posedge ref_clk);
		instr <= i;
		instr_valid <= 1'b1;
		@(posedge ref_clk);
		instr_valid <= 1'b0;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		while (instr_ready !== 1'b1 && n < 60);
		if (n >= 60) error_cnt++;
		@(posedge ref_clk);
		#1;
	endtask

	task automatic ld(input exec_pkg::op_t op, input logic [11:0] a, input logic [23:0] v);
		mem[a] = v;
		run(mk(op, a));
	endtask

	task automatic t_flow;
		logic [11:0] e;
		run(mk(exec_pkg::op_jump, 12'h100));
		run(mk(exec_pkg::op_jump, 12'h200));
		check(24'(pc), 24'h000200);
		check(24'(return_link_register), 24'h000101);
		e = 12'h200;
		for (int k = 0; k < 3; k++)
		begin
			io_count <= 12'h050;
			run(mk(exec_pkg::op_skip_on_count_check, 12'h04f + 12'(k)));
			e = e + ((k > 0) ? 12'h002 : 12'h001);
			check(24'(pc), 24'(e));
		end
		for (int k = 0; k < 2; k++)
		begin
			io_fault <= k[0];
			run(mk(exec_pkg::op_skip_on_fault, 12'h000));
			e = e + (k[0] ? 12'h001 : 12'h002);
			check(24'(pc), 24'(e));
		end
		io_fault <= 1'b0;
		$display("flow test done");
	endtask

	task automatic t_logic;
		ld(exec_pkg::op_load_operand, 12'h00a, 24'h0f0f00);
		mem[12'h00b] = 24'h00f0ff;
		run(mk(exec_pkg::op_or_merge_store, 12'h00b));
		check(operand_buf, 24'h0fffff);
		check(mem[12'h00b], 24'h0fffff);
		ld(exec_pkg::op_load_accumulator_from_memory, 12'h00c, 24'hff00ff);
		mem[12'h00d] = 24'h0ff0f0;
		run(mk(exec_pkg::op_xor_add_store, 12'h00d));
		check(operand_buf, 24'hf0f00f);
		check(mem[12'h00d], 24'hf0f00f);
		$display("logic test done");
	endtask

	task automatic t_io;
		ld(exec_pkg::op_load_operand, 12'h014, 24'h123456);
		lat <= 4'h3;
		run(mk(exec_pkg::op_issue_io_command, 12'h000));
		check(last_cmd, 24'h123456);
		check(24'(n_cmd), 24'h000001);
		for (int k = 0; k < 2; k++)
		begin
			refuse_mode <= !k[0];
			io_fault <= k[0];
			run(mk(exec_pkg::op_jump, 12'h300));
			run(mk(exec_pkg::op_issue_io_command, 12'h000));
			check(24'(pc), 24'(exec_pkg::DIAG_IO_ADDR));
			check(24'(return_link_register), 24'h000301);
			check(24'(n_cmd), 24'h000001);
		end
		refuse_mode <= 1'b0;
		io_fault <= 1'b0;
		$display("io test done");
	endtask

	task automatic t_arith;
		exec_pkg::instr_t i;
		ld(exec_pkg::op_load_multiplier, 12'h01e, 24'h400000);
		check(multiplier, 24'h400000);
		ld(exec_pkg::op_load_accumulator_from_memory, 12'h01f, 24'h200000);
		mem[12'h020] = 24'h400000;
		run(mk(exec_pkg::op_multiply_accumulate, 12'h020));
		check(acc, 24'h400000);
		ld(exec_pkg::op_load_multiplier, 12'h01e, 24'hc00000);
		i = mk(exec_pkg::op_clear_add, 12'h021);
		i.from_q = 1'b1;
		i.absval = 1'b1;
		i.store = 1'b1;
		run(i);
		check(acc, 24'h400000);
		check(mem[12'h021], 24'h400000);
		ld(exec_pkg::op_divide, 12'h022, 24'h200000);
		check(acc, 24'h200000);
		check(24'(overflow), 24'h000001);
		ld(exec_pkg::op_select_larger_word, 12'h023, 24'h300000);
		check(acc, 24'h300000);
		check(24'(return_link_register), 24'h000023);
		ld(exec_pkg::op_select_smaller_word, 12'h024, 24'h100000);
		check(acc, 24'h100000);
		check(24'(return_link_register), 24'h000024);
		ld(exec_pkg::op_load_accumulator_from_memory, 12'h025, 24'hff4000);
		mem[12'h026] = 24'hff4000;
		i = mk(exec_pkg::op_add, 12'h026);
		i.fp = 1'b1;
		run(i);
		check(24'(pc), 24'(exec_pkg::DIAG_FP_ADDR));
		check(acc, 24'hff4000);
		// Mantissa carry renormalises in floating mode, fixed add would differ
		ld(exec_pkg::op_load_accumulator_from_memory, 12'h027, 24'h014000);
		i.addr = 12'h027;
		run(i);
		check(acc, 24'h024000);
		$display("arith test done");
	endtask

	task automatic t_index;
		exec_pkg::instr_t i;
		logic [11:0] p;
		ld(exec_pkg::op_load_operand, 12'h028, 24'h000005);
		i = mk(exec_pkg::op_load_index, 12'h000);
		i.idx_sel = 3'h2;
		run(i);
		mem[12'h035] = 24'h111111;
		mem[12'h02b] = 24'h222222;
		for (int k = 0; k < 2; k++)
		begin
			i = mk(exec_pkg::op_load_accumulator_from_memory, 12'h030);
			i.idx_sel = 3'h2;
			i.idx_sub = k[0];
			run(i);
			check(acc, k[0] ? 24'h222222 : 24'h111111);
		end
		ld(exec_pkg::op_load_accumulator_from_memory, 12'h029, 24'h000000);
		p = pc;
		run(mk(exec_pkg::op_repeat_next, 12'h003));
		// The bench fetches: pc holds while the repeat runs, so offer the add again
		mem[12'h02a] = 24'h010000;
		for (int k = 0; k < 3; k++)
		begin
			run(mk(exec_pkg::op_add, 12'h02a));
			check(24'(pc), 24'(p + ((k < 2) ? 12'h001 : 12'h002)));
		end
		check(acc, 24'h030000);
		$display("index test done");
	endtask

	task automatic finish_test;
		$display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Reset, then the scenarios
	initial
	begin
		{ref_clk, rst_n, instr_valid, io_fault, refuse_mode} = 5'h00;
		instr = '0;
		io_count = 12'h000;
		lat = 4'h1;
		error_cnt = 0;
		cmp_count = 0;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_flow;
		t_logic;
		t_io;
		t_arith;
		t_index;
		finish_test;
	end
	// Watchdog
	initial
	begin
		#200000;
		error_cnt++;
		finish_test;
	end
endmodule // tb_top
`default_nettype wire
